// ### inc/tch_pkg.sv
// tch_pkg: constants and types for the touch controller host bring-up block.
// assumes a single 10 MHz clock domain; no register bus, all controls are ports.
package tch_pkg;
  localparam int          TCH_CLK_HZ       = 10_000_000;
  localparam int          TCH_MSG_W        = 16;
  localparam int          TCH_MSG_DEPTH    = 8;
  localparam int          TCH_CFG_W        = 8;
  localparam int          TCH_OBJ_W        = 4;
  localparam int          TCH_CMD_W        = 8;
  // object identifiers on the object port
  localparam logic [3:0]  TCH_OBJ_MSG      = 4'h0;
  localparam logic [3:0]  TCH_OBJ_CMD      = 4'h1;
  localparam logic [3:0]  TCH_OBJ_PWR      = 4'h2;
  localparam logic [3:0]  TCH_OBJ_ACQ      = 4'h3;
  localparam logic [3:0]  TCH_OBJ_DIAG     = 4'h4;
  localparam logic [3:0]  TCH_OBJ_USER     = 4'h5;
  localparam logic [3:0]  TCH_OBJ_CNT      = 4'h6;
  localparam logic [3:0]  TCH_OBJ_OPT      = 4'h7;
  // command codes written to the command object
  localparam logic [7:0]  TCH_CMD_SAVE     = 8'h55;
  // field reset value: zero is the safe, disabled default
  localparam logic [7:0]  TCH_CFG_RST      = 8'h00;
  // start-up message posted after reset
  localparam logic [15:0] TCH_MSG_RESET    = 16'h0180;
  // strap level selecting HID-over-I2C
  localparam logic        TCH_STRAP_HID    = 1'b0;
  typedef enum logic [2:0] {
    TCH_ST_BOOT = 3'b001,
    TCH_ST_I2C  = 3'b010,
    TCH_ST_HID  = 3'b100
  } tch_state_t;
endpackage

// ### core/tch_core.sv
// tch_core: message store, change line, object write filter and save trigger.
// assumes synchronous inputs on clk; the bus front end decodes host transfers.
`timescale 1ns/1ps
// Summary of operation
// R1: after reset, post a start-up message and pull change line low (the code pulls it low in plain I2C mode only, never in HID mode).
// R2: host deems device faulty if change line never falls.
// R3: host drains all pending messages after power-up or reset.
// R4: host checks drained messages for configuration errors.
// R5: strap held at ground selects HID-over-I2C.
// R6: host reads object table and keeps object start addresses.
// R7: host derives report ID ranges from the object table.
// R8: host sends commands by writing the command object.
// R9: optional objects stay inactive until the host enables them.
// R10: in plain I2C mode, change line asserts when a message is waiting.
// R11: in HID mode messages are pushed out automatically as reports.
// R12: host waits for notification rather than polling.
// R13: every configuration field resets to zero, the safe disabled value.
// R14: host configures objects then commands a save to nonvolatile memory.
// R15: host enables object, sets fields, then enables reporting.
// R16: read-only objects readable without setup and reject configuration writes.
// R17: host configures power and acquisition objects before use.
// R18: host limits nonvolatile saves to the rated lifetime count.
// R19: change line released once the message store is empty.
module tch_core
  import tch_pkg::*;
#(
  parameter int DEPTH = tch_pkg::TCH_MSG_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // strap
  input  wire logic                          interface_select_strap,
  // new messages from acquisition
  input  wire logic                          msg_in_valid,
  input  wire logic [tch_pkg::TCH_MSG_W-1:0] msg_in_data,
  // host message read
  input  wire logic                          msg_read,
  output logic      [tch_pkg::TCH_MSG_W-1:0] msg_rd_data,
  output logic                               msg_rd_valid,
  // HID auto report
  input  wire logic                          report_ready,
  output logic                               report_valid,
  output logic      [tch_pkg::TCH_MSG_W-1:0] report_data,
  // object write
  input  wire logic                          obj_wr,
  input  wire logic [tch_pkg::TCH_OBJ_W-1:0] obj_sel,
  input  wire logic [tch_pkg::TCH_CFG_W-1:0] obj_wr_data,
  output logic                               obj_wr_reject,
  // configuration state
  output logic      [tch_pkg::TCH_CFG_W-1:0] power_config_object,
  output logic      [tch_pkg::TCH_CFG_W-1:0] acquisition_config_object,
  output logic                               optional_enable,
  output logic                               nv_save_pulse,
  // change line (open drain) and interface mode
  output logic                               change_notify_n_o,
  output logic                               change_notify_n_oe,
  output logic                               hid_mode
);
  import tch_pkg::*;

  localparam int AW = $clog2(DEPTH);

  function automatic logic obj_read_only(input logic [TCH_OBJ_W-1:0] s);
    obj_read_only = (s == TCH_OBJ_MSG) || (s == TCH_OBJ_DIAG) ||
                    (s == TCH_OBJ_USER) || (s == TCH_OBJ_CNT);
  endfunction

  tch_state_t            state_q;
  logic [TCH_MSG_W-1:0]  mem_q [DEPTH];
  logic [AW-1:0]         wp_q;
  logic [AW-1:0]         rp_q;
  logic [AW:0]           cnt_q;
  logic                  boot_post;
  logic                  push;
  logic                  pop;
  logic [TCH_MSG_W-1:0]  push_data;
  logic                  empty;

  assign empty     = (cnt_q == '0);
  assign boot_post = (state_q == TCH_ST_BOOT);
  assign push      = boot_post || (msg_in_valid && (cnt_q != (AW+1)'(DEPTH)));
  assign push_data = boot_post ? TCH_MSG_RESET : msg_in_data;
  assign pop       = !empty && ((state_q == TCH_ST_I2C) ? msg_read
                                : (state_q == TCH_ST_HID) && report_valid && report_ready);

  // strap sampled once after reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TCH_ST_BOOT;
      hid_mode <= 1'b0;
    end else begin
      case (state_q)
        TCH_ST_BOOT: begin
          if (interface_select_strap == TCH_STRAP_HID) begin // [R5]
            state_q <= TCH_ST_HID;
            hid_mode <= 1'b1;
          end else begin
            state_q <= TCH_ST_I2C;
          end
        end
        TCH_ST_I2C: state_q <= TCH_ST_I2C;
        TCH_ST_HID: state_q <= TCH_ST_HID;
        default: state_q <= TCH_ST_BOOT;
      endcase
    end
  end

  // message store, start-up message posted on leaving boot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop); // [R1]
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= push_data;
    end
  end

  // plain I2C read answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_rd_data  <= '0;
      msg_rd_valid <= 1'b0;
    end else begin
      msg_rd_valid <= pop && (state_q == TCH_ST_I2C);
      if (pop && (state_q == TCH_ST_I2C)) begin
        msg_rd_data <= mem_q[rp_q];
      end
    end
  end

  // HID auto report, presented without host request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      report_valid <= 1'b0;
      report_data  <= '0;
    end else if (!report_valid || report_ready) begin
      report_valid <= (state_q == TCH_ST_HID) && (cnt_q > (AW+1)'(pop)); // [R11]
      report_data  <= pop ? mem_q[rp_q + 1'b1] : mem_q[rp_q];
    end
  end

  // change line: low while messages wait in plain mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      change_notify_n_oe <= 1'b1;
    end else begin
      change_notify_n_oe <= !((state_q == TCH_ST_I2C) &&
                              (cnt_q + (AW+1)'(push) - (AW+1)'(pop) != '0)); // [R10] [R19]
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      change_notify_n_o <= 1'b0;
    end else begin
      change_notify_n_o <= 1'b0;
    end
  end

  // object configuration, zero defaults, read-only objects refuse writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_config_object       <= TCH_CFG_RST; // [R13]
      acquisition_config_object <= TCH_CFG_RST; // [R13]
      optional_enable           <= 1'b0;        // [R9]
      nv_save_pulse             <= 1'b0;
      obj_wr_reject             <= 1'b0;
    end else begin
      nv_save_pulse <= 1'b0;
      obj_wr_reject <= obj_wr && obj_read_only(obj_sel); // [R16]
      if (obj_wr && !obj_read_only(obj_sel)) begin
        case (obj_sel)
          TCH_OBJ_PWR: power_config_object <= obj_wr_data;
          TCH_OBJ_ACQ: acquisition_config_object <= obj_wr_data;
          TCH_OBJ_OPT: optional_enable <= obj_wr_data[0]; // [R9]
          TCH_OBJ_CMD: nv_save_pulse <= (obj_wr_data == TCH_CMD_SAVE); // [R8]
          default: ;
        endcase
      end
    end
  end

  // change line tracks store in plain mode
  property notify_low_p;
    @(posedge clk) disable iff (!rst_b)
      (state_q == TCH_ST_I2C && cnt_q != '0 && !pop) |=> !change_notify_n_oe;
  endproperty
  notify_low_a: assert property (notify_low_p) else $error("change line not driven low with message waiting"); // [R10]

  notify_release_a: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
    (cnt_q == '0 && !push) |=> change_notify_n_oe)
    else $error("change line held low with empty store");

  sequence boot_seq;
    state_q == TCH_ST_BOOT ##1 state_q == TCH_ST_I2C;
  endsequence
  // line falls one edge after the first plain-mode cycle
  boot_notify_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    boot_seq |=> !change_notify_n_oe)
    else $error("no change notification after start-up");

  ro_reject_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
    (obj_wr && obj_read_only(obj_sel)) |=> obj_wr_reject && $stable(power_config_object))
    else $error("read-only object accepted a write");

  hid_report_a: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
    (state_q == TCH_ST_HID && cnt_q != '0 && !report_valid) |=> report_valid)
    else $error("hid message not reported");

  hid_quiet_a: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
    hid_mode |-> change_notify_n_oe ##1 change_notify_n_oe)
    else $error("change line used in hid mode");

  opt_off_a: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    (!(obj_wr && obj_sel == TCH_OBJ_OPT)) |=> optional_enable == $past(optional_enable))
    else $error("optional object enabled without host write");

  save_cmd_a: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    nv_save_pulse |-> $past(obj_wr) && $past(obj_sel) == TCH_OBJ_CMD && $past(obj_wr_data) == TCH_CMD_SAVE)
    else $error("save pulse without save command");

  strap_hid_a: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    (state_q == TCH_ST_BOOT && interface_select_strap == TCH_STRAP_HID) |=> hid_mode)
    else $error("strap at ground did not select hid mode");
endmodule

// ### test/tch_host.sv
// tch_host: host model that drains messages from the block.
// assumes clk-synchronous ports; drives 1 ns after the rising edge.
`timescale 1ns/1ps
module tch_host (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // bench control
  input  wire logic host_en,
  // device side
  input  wire logic change_notify_n,
  input  wire logic hid_mode,
  output logic      msg_read,
  output logic      report_ready
);
  logic stall_q;
  initial begin
    msg_read = 1'b0;
    report_ready = 1'b0;
    stall_q = 1'b0;
  end
  always @(posedge clk) begin
    #1;
    stall_q <= ~stall_q;
    // read only once notified, never poll
    msg_read <= rst_b && host_en && hid_mode !== 1'b1 && change_notify_n === 1'b0;
    // every other cycle stalled, so a report must hold
    report_ready <= rst_b && host_en && hid_mode === 1'b1 && stall_q;
  end
endmodule

// ### test/tch_core_bench.sv
// tch_core_bench: self-checking bench for tch_core with a host model.
// assumes tch_pkg compiled first; expected messages queue in expq.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH t=%0t value differs", $time); end end
module tch_core_bench;
  import tch_pkg::*;
  logic                 clk, rst_b, strap, host_en, msg_in_valid, obj_wr, notify_n, rd, rdy;
  logic                 rd_v, rpt_v, rej, opt_en, save, notify_o, notify_oe, hid;
  logic [TCH_MSG_W-1:0] msg_in_data, rd_data, rpt_data, got;
  logic [TCH_OBJ_W-1:0] obj_sel;
  logic [TCH_CFG_W-1:0] obj_wr_data, pwr, acq;
  logic [TCH_MSG_W-1:0] expq[$];
  int                   bad_count, num_checks, seed, i;
  // released line reads high through its pull-up
  assign notify_n = notify_oe ? 1'b1 : notify_o;
  tch_core DUT (.clk(clk), .rst_b(rst_b), .interface_select_strap(strap), .msg_in_valid(msg_in_valid),
    .msg_in_data(msg_in_data), .msg_read(rd), .msg_rd_data(rd_data), .msg_rd_valid(rd_v),
    .report_ready(rdy), .report_valid(rpt_v), .report_data(rpt_data), .obj_wr(obj_wr), .obj_sel(obj_sel),
    .obj_wr_data(obj_wr_data), .obj_wr_reject(rej), .power_config_object(pwr), .acquisition_config_object(acq),
    .optional_enable(opt_en), .nv_save_pulse(save), .change_notify_n_o(notify_o), .change_notify_n_oe(notify_oe),
    .hid_mode(hid));
  tch_host host (.clk(clk), .rst_b(rst_b), .host_en(host_en), .change_notify_n(notify_n), .hid_mode(hid),
    .msg_read(rd), .report_ready(rdy));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // result watcher
  always @(posedge clk) begin
    if (rd_v === 1'b1 || (rpt_v === 1'b1 && rdy === 1'b1)) begin
      if (expq.size() == 0)
        `CHK(1'b1, 1'b0)
      else begin
        got = expq.pop_front();
        `CHK((rd_v === 1'b1) ? rd_data : rpt_data, got)
      end
    end
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    rst_b = 1'b0;
    strap = s;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    expq.push_back(TCH_MSG_RESET);
    repeat (2) @(posedge clk);
    #1;
    `CHK({pwr, acq, opt_en}, 17'h0)
    `CHK(hid, ~s)
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    obj_wr = 1'b1;
    obj_sel = s;
    obj_wr_data = d;
    @(posedge clk);
    #1;
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 300 && expq.size() != 0; n++) @(posedge clk);
    if (expq.size() != 0) begin
      bad_count++;
      $display("MISMATCH t=%0t drain timeout", $time);
      tally_and_finish();
    end else begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task automatic push(input int cnt, input int keep);
    msg_in_valid = 1'b1;
    for (int k = 0; k < cnt; k++) begin
      msg_in_data = 16'($random(seed));
      if (k < keep) expq.push_back(msg_in_data);
      @(posedge clk);
      #1;
    end
    msg_in_valid = 1'b0;
  endtask
  initial begin
    {rst_b, msg_in_valid, obj_wr, obj_sel, obj_wr_data, msg_in_data} = '0;
    {strap, host_en} = 2'b11;
    {bad_count, num_checks} = 0;
    seed = 32'h674B;
    do_reset(1'b1);
    `CHK(notify_oe, 1'b0)
    drain();
    `CHK(notify_oe, 1'b1)
    // write strobe held up across back-to-back writes
    for (i = 0; i < 8; i++) begin
      wr(i[3:0], 8'h10 + 8'(i));
      `CHK(rej, 1'(i inside {0, 4, 5, 6}))
      `CHK(save, 1'b0)
    end
    `CHK({pwr, acq, opt_en}, 17'h2427)
    wr(TCH_OBJ_CMD, TCH_CMD_SAVE);
    `CHK(save, 1'b1)
    wr(TCH_OBJ_OPT, 8'h00);
    `CHK({save, opt_en}, 2'b00)
    obj_wr = 1'b0;
    host_en = 1'b0;
    push(9, TCH_MSG_DEPTH);
    `CHK(notify_oe, 1'b0)
    host_en = 1'b1;
    drain();
    `CHK(notify_oe, 1'b1)
    do_reset(1'b0);
    `CHK(rpt_v, 1'b1)
    push(4, 4);
    `CHK(notify_oe, 1'b1)
    drain();
    `CHK(rpt_v, 1'b0)
    tally_and_finish();
  end
endmodule
